// ### hdl/lrc_ladder_ctrl.sv
/*
  ladder reference control: one 8-bit software register decoded into
  power, pad routing, range, source and one-hot tap controls.
  assumes a synchronous strobe bus master and an analog ladder that
  takes the decoded controls; sleep is not seen here at all.
*/
`timescale 1ns/10ps
module lrc_ladder_ctrl
  import lrc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // ladder controls
  output logic             ladder_power_enable,
  output logic             ladder_pad_output_enable,
  output logic             ladder_range_select,
  output logic             ladder_source_select,
  output logic      [3:0]  ladder_tap_value,
  output logic      [31:0] ladder_tap_onehot
);
  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  // read data fall back to zero outside a read, so the port can be
  // ORed with other slaves without a select of its own

  // no sleep or comparator input exists, so neither can alter it
  always_comb begin
    ctrl_next = ctrl_reg;
    if (reg_wr && reg_addr == LRC_CTRL_ADDR) begin
      ctrl_next = reg_wdata;
    end
    rdata_next = LRC_UNMAPPED_READ;
    if (reg_rd && reg_addr == LRC_CTRL_ADDR) begin
      rdata_next = ctrl_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_reg  <= LRC_CTRL_RESET;
      rdata_reg <= LRC_UNMAPPED_READ;
    end else begin
      ctrl_reg  <= ctrl_next;
      rdata_reg <= rdata_next;
    end
  end

  // ------------------------------------------------------------
  // tap decode
  // ------------------------------------------------------------
  // high range starts a quarter up the 32-step span; low range uses
  // the bottom of the 24-step span, so one 32-tap vector serves both
  logic [4:0]  tap_pos;
  logic [31:0] onehot_next;
  logic [31:0] onehot_reg;

  always_comb begin
    if (ctrl_next[LRC_RANGE_BIT]) begin
      tap_pos = {1'b0, ctrl_next[LRC_TAP_MSB:LRC_TAP_LSB]};
    end else begin
      tap_pos = LRC_HIGH_BASE_TAP +
                {1'b0, ctrl_next[LRC_TAP_MSB:LRC_TAP_LSB]};
    end
  end

  lrc_tap_decode #(.N(32)) i_lrc_tap_decode (
    .pos (tap_pos),
    .en  (ctrl_next[LRC_POWER_BIT]),
    .sel (onehot_next)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      onehot_reg <= '0;
    end else begin
      onehot_reg <= onehot_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // every output is a plain flop bit, so no decode glitch can reach
  // the analog switches while a write lands
  assign reg_rdata                = rdata_reg;
  assign ladder_power_enable      = ctrl_reg[LRC_POWER_BIT];
  assign ladder_pad_output_enable = ctrl_reg[LRC_PAD_BIT];
  assign ladder_range_select      = ctrl_reg[LRC_RANGE_BIT];
  assign ladder_source_select     = ctrl_reg[LRC_SOURCE_BIT];
  assign ladder_tap_value = ctrl_reg[LRC_TAP_MSB:LRC_TAP_LSB];
  assign ladder_tap_onehot        = onehot_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // every field is held against the bus word of the edge before, so a
  // slip in a field position shows even though the outputs are plain
  // register bits

  a_write_takes: assert property (
    @(posedge clk) disable iff (sys_rst)
    reg_wr && reg_addr == LRC_CTRL_ADDR |=> ctrl_reg == $past(reg_wdata))
    else $error("control write not stored");

  a_read_returns: assert property (
    @(posedge clk) disable iff (sys_rst)
    reg_rd && reg_addr == LRC_CTRL_ADDR |=> reg_rdata == $past(ctrl_reg))
    else $error("read data wrong");

  // read data stand one cycle only, so a stale word cannot pass for a
  // fresh read
  a_rdata_idle: assert property (
    @(posedge clk) disable iff (sys_rst)
    !(reg_rd && reg_addr == LRC_CTRL_ADDR) |=>
      reg_rdata == LRC_UNMAPPED_READ)
    else $error("read data outside a read");

  a_unmapped_read: assert property (
    @(posedge clk) disable iff (sys_rst)
    reg_rd && reg_addr != LRC_CTRL_ADDR |=>
      reg_rdata == LRC_UNMAPPED_READ)
    else $error("unmapped read returned data");

  // nothing but a bus write may move the register: no sleep or
  // comparator path reaches it
  a_hold_idle: assert property (
    @(posedge clk) disable iff (sys_rst)
    !(reg_wr && reg_addr == LRC_CTRL_ADDR) |=> $stable(ctrl_reg))
    else $error("register changed without write");

  a_reset_clears: assert property (
    @(posedge clk)
    sys_rst |=> ctrl_reg == LRC_CTRL_RESET && onehot_reg == '0)
    else $error("reset did not clear");

  a_reset_outputs: assert property (
    @(posedge clk)
    sys_rst |=> reg_rdata == LRC_UNMAPPED_READ && !ladder_power_enable &&
      !ladder_pad_output_enable && !ladder_range_select &&
      !ladder_source_select && ladder_tap_value == 4'h0)
    else $error("outputs not cleared by reset");

  // field by field after a write
  a_power_write: assert property (
    @(posedge clk) disable iff (sys_rst)
    reg_wr && reg_addr == LRC_CTRL_ADDR |=>
      ladder_power_enable == $past(reg_wdata[LRC_POWER_BIT]))
    else $error("power enable not taken from write");

  a_pad_write: assert property (
    @(posedge clk) disable iff (sys_rst)
    reg_wr && reg_addr == LRC_CTRL_ADDR |=>
      ladder_pad_output_enable == $past(reg_wdata[LRC_PAD_BIT]))
    else $error("pad enable not taken from write");

  a_range_write: assert property (
    @(posedge clk) disable iff (sys_rst)
    reg_wr && reg_addr == LRC_CTRL_ADDR |=>
      ladder_range_select == $past(reg_wdata[LRC_RANGE_BIT]))
    else $error("range select not taken from write");

  a_source_write: assert property (
    @(posedge clk) disable iff (sys_rst)
    reg_wr && reg_addr == LRC_CTRL_ADDR |=>
      ladder_source_select == $past(reg_wdata[LRC_SOURCE_BIT]))
    else $error("source select not taken from write");

  a_tap_write: assert property (
    @(posedge clk) disable iff (sys_rst)
    reg_wr && reg_addr == LRC_CTRL_ADDR |=>
      ladder_tap_value == $past(reg_wdata[LRC_TAP_MSB:LRC_TAP_LSB]))
    else $error("tap value not taken from write");

  // a powered-down ladder selects no tap, a powered one exactly one
  a_power_off: assert property (
    @(posedge clk) disable iff (sys_rst)
    !ladder_power_enable |-> onehot_reg == '0)
    else $error("tap active while powered down");

  a_power_on: assert property (
    @(posedge clk) disable iff (sys_rst)
    ladder_power_enable |-> $onehot(onehot_reg))
    else $error("powered ladder without a single tap");

  a_low_tap: assert property (
    @(posedge clk) disable iff (sys_rst)
    ladder_power_enable && ladder_range_select |->
      onehot_reg == (32'h1 << ladder_tap_value))
    else $error("low range tap wrong");

  a_high_tap: assert property (
    @(posedge clk) disable iff (sys_rst)
    ladder_power_enable && !ladder_range_select |->
      onehot_reg == (32'h100 << ladder_tap_value))
    else $error("high range tap wrong");

  // the high range never reaches below a quarter of the span
  a_high_floor: assert property (
    @(posedge clk) disable iff (sys_rst)
    ladder_power_enable && !ladder_range_select |->
      (onehot_reg & ((32'h1 << LRC_HIGH_BASE_TAP) - 32'h1)) == 32'h0)
    else $error("high range tap below its floor");

  // main scenarios
  c_write: cover property (@(posedge clk) reg_wr ##1 reg_rd);
  c_low_on: cover property (@(posedge clk)
    ladder_power_enable && ladder_range_select);
  c_high_pad: cover property (@(posedge clk)
    ladder_power_enable && ladder_pad_output_enable && !ladder_range_select);
  c_ext_source: cover property (@(posedge clk)
    ladder_power_enable && ladder_source_select);
  c_mid_reset: cover property (@(posedge clk)
    ladder_power_enable ##1 sys_rst ##1 !ladder_power_enable);
endmodule // lrc_ladder_ctrl

// ### hdl/lrc_pkg.sv
/*
  package for the ladder reference control block: register layout,
  reset value and decode constants.
  assumes a single 8-bit control register on a plain strobe port.
*/
// What this block does
// - bit 7 powers the ladder on or off
// - bit 6 drives level onto pad, overrides direction
// - bit 5: 1 low range /24, 0 high /32
// - bit 4: 1 external reference pins, 0 supply rails
// - bits 3..0 pick tap within chosen range
// - reset clears enable, pad, range and value bits
// - sleep wake-up leaves the register unchanged
// - works independent of comparator mode settings
package lrc_pkg;
  localparam logic [3:0] LRC_CTRL_ADDR     = 4'h0;
  localparam logic [7:0] LRC_CTRL_RESET    = 8'h00;
  localparam int         LRC_POWER_BIT     = 7;
  localparam int         LRC_PAD_BIT       = 6;
  localparam int         LRC_RANGE_BIT     = 5;
  localparam int         LRC_SOURCE_BIT    = 4;
  localparam int         LRC_TAP_MSB       = 3;
  localparam int         LRC_TAP_LSB       = 0;
  localparam logic [4:0] LRC_HIGH_BASE_TAP = 5'h08;
  localparam logic [7:0] LRC_UNMAPPED_READ = 8'h00;
  localparam logic [4:0] LRC_LOW_STEPS     = 5'h18;
  localparam logic [4:0] LRC_HIGH_STEPS    = 5'h20;
endpackage

// ### hdl/lrc_tap_decode.sv
/*
  one-hot ladder tap decoder: turns a tap position into a select vector.
  assumes the position is already in range of the ladder length.
*/
`timescale 1ns/10ps
module lrc_tap_decode #(
  parameter int N = 32
) (
  // position in
  input  wire logic [$clog2(N)-1:0] pos,
  input  wire logic                 en,
  // one-hot out
  output logic      [N-1:0]         sel
);
  always_comb begin
    sel = '0;
    if (en) begin
      sel[pos] = 1'b1;
    end
  end
endmodule // lrc_tap_decode

// ### test/test_lrc_ladder_ctrl.sv
/*
  self-checking bench for lrc_ladder_ctrl: corner and random writes,
  back-to-back read-back, unmapped access, mid-run reset.
  assumes lrc_pkg and a single clock domain.
*/
`timescale 1ns/10ps
module test_lrc_ladder_ctrl
  import lrc_pkg::*;
;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic [7:0]  cur;
  logic        pwr, pad, rng, src;
  logic [3:0]  tap;
  logic [31:0] hot;
  int          fail_count = 0;
  int          num_checks = 0;

  always #50 clk = ~clk;

  lrc_ladder_ctrl i_lrc_ladder_ctrl (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ladder_power_enable(pwr),
    .ladder_pad_output_enable(pad), .ladder_range_select(rng),
    .ladder_source_select(src), .ladder_tap_value(tap),
    .ladder_tap_onehot(hot));

  // ---------------------------------------------------------------
  // expectations and checks
  // ---------------------------------------------------------------
  // high range sits above the low one on the shared ladder
  function automatic logic [31:0] exp_hot(logic [7:0] v);
    if (!v[LRC_POWER_BIT]) return 32'h0;
    return 32'h1 << (v[3:0] + (v[LRC_RANGE_BIT] ? 5'h00 : LRC_HIGH_BASE_TAP));
  endfunction

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_out();
    chk({pwr, pad, rng, src, tap}, cur);
    chk(hot, exp_hot(cur));
  endtask

  // write, then read at the very next edge: no gap on purpose
  task automatic xfer(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    #1;
    if (a == LRC_CTRL_ADDR) cur = d;
    chk_out();
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, a == LRC_CTRL_ADDR ? cur : LRC_UNMAPPED_READ);
    @(posedge clk);
    #1;
    chk(reg_rdata, 8'h00);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(17));
    cur = LRC_CTRL_RESET;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    chk_out();
    xfer(4'h0, 8'h80);
    xfer(4'h0, 8'hbf);
    xfer(4'h0, 8'h8f);
    xfer(4'h0, 8'h7f);
    xfer(4'h3, 8'hff);
    repeat (40) xfer(($urandom_range(0, 3) == 0) ?
      4'($urandom_range(1, 15)) : 4'h0, 8'($urandom));
    xfer(4'h0, 8'h5a);
    xfer(4'h0, 8'hff);
    // reset in mid-run must drop everything at once
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    cur = LRC_CTRL_RESET;
    chk_out();
    xfer(4'h1, 8'h00);
    final_report();
  end
endmodule // test_lrc_ladder_ctrl
